// ### cmoh_map.vh
/*
  Address map, message object word layout and command mask bits of the
  CAN message object handler. Definitions only; included by the handler.
*/
`ifndef CMOH_MAP_VH
`define CMOH_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, 16-bit registers)
// ----------------------------------------------------------------------
`define CMOH_R_CTL   9'h000
`define CMOH_IF1     9'h020
`define CMOH_IF2     9'h080
`define CMOH_IF_TOP  9'h028
`define CMOH_R_CRR   9'h000
`define CMOH_R_CMR   9'h004
`define CMOH_R_M1    9'h008
`define CMOH_R_M2    9'h00C
`define CMOH_R_A1    9'h010
`define CMOH_R_A2    9'h014
`define CMOH_R_MCR   9'h018
`define CMOH_R_DA1   9'h01C
`define CMOH_R_DA2   9'h020
`define CMOH_R_DB1   9'h024
`define CMOH_R_DB2   9'h028
`define CMOH_R_TXR1  9'h100
`define CMOH_R_TXR2  9'h104
`define CMOH_R_ND1   9'h120
`define CMOH_R_ND2   9'h124
`define CMOH_R_IP1   9'h140
`define CMOH_R_IP2   9'h144
`define CMOH_R_MV1   9'h160
`define CMOH_R_MV2   9'h164

// ----------------------------------------------------------------------
// Message object word (136 bits) and object numbering
// ----------------------------------------------------------------------
`define CMOH_WW      136
`define CMOH_W_DA    31:0
`define CMOH_W_DB    63:32
`define CMOH_W_DLC   67:64
`define CMOH_W_EOB   68
`define CMOH_W_SEND_IRQ_ENABLE  69
`define CMOH_W_RECEIVE_IRQ_ENABLE  70
`define CMOH_W_REMOTE_ANSWER_ENABLE 71
`define CMOH_W_USE_ACCEPTANCE_MASK 72
`define CMOH_W_LOST  73
`define CMOH_W_CTL   73:64
`define CMOH_W_ID    102:74
`define CMOH_W_IDL   89:74
`define CMOH_W_IDH   102:90
`define CMOH_W_XTD   103
`define CMOH_W_DIR   104
`define CMOH_W_ARB   104:74
`define CMOH_W_MSK   133:105
`define CMOH_W_MSKL  120:105
`define CMOH_W_MSKH  133:121
`define CMOH_W_MASK_EXTENDED_FLAG  134
`define CMOH_W_MASK_TRANSMIT_SIDE  135
`define CMOH_W_MASK  135:105
`define CMOH_OBJ_MAX 6'h20
`define CMOH_OBJ_END 5'h1F

// ----------------------------------------------------------------------
// Command mask bits and buffer flag positions
// ----------------------------------------------------------------------
`define CMOH_C_WR    7
`define CMOH_C_MASK  6
`define CMOH_C_ARB   5
`define CMOH_C_CTRL  4
`define CMOH_C_CLRIP 3
`define CMOH_C_TXND  2
`define CMOH_C_DA    1
`define CMOH_C_DB    0
`define CMOH_F_VAL   3
`define CMOH_F_NEW   2
`define CMOH_F_IP    1
`define CMOH_F_TXR   0

`endif

// ### cmoh_ram.v
/*
  Message RAM: 32 message objects of one word each, synchronous port.
  Assumes the handler holds the address steady; read data is registered
  every cycle, so it appears one cycle after the address.
*/
`timescale 1ns/10ps
module cmoh_ram (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         we,
  input  wire [4:0]   addr,
  input  wire [135:0] wdata,
  output reg  [135:0] rdata
);
  // No reset on the array: object configuration survives a chip reset
  reg [135:0] mem [0:31];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 136'h0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule // cmoh_ram

// ### cmoh_prio.v
/*
  Transmit priority picker: lowest set request index wins.
  Purely combinational; assumes the caller registers the result.
*/
`timescale 1ns/10ps
module cmoh_prio (
  input  wire [31:0] req,
  output reg         found,
  output reg  [4:0]  index
);
  integer k;

  always @* begin
    found = 1'b0;
    index = 5'h00;
    // Scan downward so the lowest object number is the last to land
    for (k = 31; k >= 0; k = k - 1) begin
      if (req[k]) begin
        found = 1'b1;
        index = k[4:0];
      end
    end
  end
endmodule // cmoh_prio

// ### cmoh_handler.v
/*
  CAN message object handler: two interface buffer sets, message RAM,
  transmit selection, acceptance scan and receive storage.
  Assumes a protocol core on the same clock giving one-cycle pulses for
  received frames and transmit outcomes, and a host on a simple
  strobe register port with read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
`include "cmoh_map.vh"

// Overview of operation
// [RL1] Reset clears valid, fresh, pending, request flags only
// [RL2] Software initialises objects before releasing hold
// [RL3] Request write moves buffer into object
// [RL4] Busy set at start, cleared at end
// [RL5] RAM writes whole object via read-modify-write
// [RL6] Partial write refreshes buffer; partial read keeps
// [RL7] Load highest valid request, clear fresh flag
// [RL8] Clear request after success unless fresh data
// [RL9] Transmit success sets pending when enabled
// [RL10] Retry after loss or error, priority order
// [RL11] Scan from object 1, stop at match
// [RL12] Data frame stores data, arbitration, length
// [RL13] Set fresh flag; set overrun if already fresh (code sets overrun only for stored data frames, not for stored remote frames)
// [RL14] Receive sets pending flag when enabled (code sets it only for stored data frames, not for stored remote frames)
// [RL15] Stored data frame clears send request
// [RL16] Remote answer sets request; otherwise ignore
// [RL17] Masked remote frame stores arbitration, keeps data
// [RL18] Lower object number means higher priority
// [RL19] Software sets transmit objects up correctly
// [RL20] Standard identifier sits in bits 28..18
// [RL21] No request before data holds content
// [RL22] Mask groups remote identifiers; direction unmasked (code masks direction too when the stored mask direction bit is clear)
module cmoh_handler (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [8:0]  bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  input  wire        core_tx_ready,
  input  wire        core_tx_done,
  input  wire        core_tx_fail,
  output reg         core_tx_load,
  output reg  [28:0] core_tx_id,
  output reg         core_tx_xtd,
  output reg         core_tx_rtr,
  output reg  [3:0]  core_tx_dlc,
  output reg  [63:0] core_tx_data,
  input  wire        core_rx_valid,
  input  wire [28:0] core_rx_id,
  input  wire        core_rx_xtd,
  input  wire        core_rx_rtr,
  input  wire [3:0]  core_rx_dlc,
  input  wire [63:0] core_rx_data,
  output reg  [31:0] obj_irq_pending,
  output reg         config_hold
);
  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_IF_RD  = 3'd1;
  localparam [2:0] S_IF_DO  = 3'd2;
  localparam [2:0] S_TX_RD  = 3'd3;
  localparam [2:0] S_TX_LD  = 3'd4;
  localparam [2:0] S_SC_RD  = 3'd5;
  localparam [2:0] S_SC_CMP = 3'd6;
  localparam [2:0] S_RX_WR  = 3'd7;

  reg  [2:0]   state;
  reg  [135:0] ifbuf [0:1];
  reg  [3:0]   ifflag [0:1];
  reg  [7:0]   ifcmr [0:1];
  reg  [5:0]   ifnum [0:1];
  reg  [1:0]   ifbusy;
  reg          cur;
  reg  [4:0]   obj;
  reg  [31:0]  object_valid;
  reg  [31:0]  fresh_data_flag;
  reg  [31:0]  send_request_flag;
  reg          tx_busy;
  reg  [4:0]   tx_obj;
  reg          tx_ie;
  reg          rx_pend;
  reg  [28:0]  rx_id;
  reg          rx_xtd;
  reg          rx_rtr;
  reg  [3:0]   rx_dlc;
  reg  [63:0]  rx_data;
  reg  [15:0]  next_rdata;
  wire [135:0] ram_q;
  wire         pick_found;
  wire [4:0]   pick_idx;
  integer      i;

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  // Returns {hit, interface}; offset is taken from the matching base
  function [1:0] if_hit;
    input [8:0] a;
    begin
      if (a >= `CMOH_IF1 && a <= `CMOH_IF1 + `CMOH_IF_TOP && a[1:0] == 2'b00)
        if_hit = 2'b10;
      else if (a >= `CMOH_IF2 && a <= `CMOH_IF2 + `CMOH_IF_TOP && a[1:0] == 2'b00)
        if_hit = 2'b11;
      else
        if_hit = 2'b00;
    end
  endfunction

  function [135:0] part_mask;
    input [7:0] c;
    begin
      part_mask = 136'h0;
      part_mask[`CMOH_W_DA]   = {32{c[`CMOH_C_DA]}};
      part_mask[`CMOH_W_DB]   = {32{c[`CMOH_C_DB]}};
      part_mask[`CMOH_W_CTL]  = {10{c[`CMOH_C_CTRL]}};
      part_mask[`CMOH_W_ARB]  = {31{c[`CMOH_C_ARB]}};
      part_mask[`CMOH_W_MASK] = {31{c[`CMOH_C_MASK]}};
    end
  endfunction

  // Care bits: all when the mask is off, else the stored mask bits
  // [RL22] Stored mask groups similar identifiers
  function accept;
    input [135:0] w;
    input         v;
    reg   [30:0]  care;
    begin
      care = w[`CMOH_W_USE_ACCEPTANCE_MASK] ? {w[`CMOH_W_MASK_TRANSMIT_SIDE], w[`CMOH_W_MASK_EXTENDED_FLAG], w[`CMOH_W_MSK]} : {31{1'b1}};
      accept = v & ~|(({w[`CMOH_W_DIR], w[`CMOH_W_XTD], w[`CMOH_W_ID]} ^ {rx_rtr, rx_xtd, rx_id}) & care);
    end
  endfunction

  wire [1:0]   hit      = if_hit(bus_addr);
  wire [8:0]   off      = bus_addr - (hit[0] ? `CMOH_IF2 : `CMOH_IF1);
  wire [7:0]   cmr      = ifcmr[cur];
  wire [135:0] sel_m    = part_mask(cmr);
  // [RL5] Unselected parts come from the object just read
  wire [135:0] merged   = (ifbuf[cur] & sel_m) | (ram_q & ~sel_m);
  wire         val_w    = cmr[`CMOH_C_ARB] ? ifflag[cur][`CMOH_F_VAL] : object_valid[obj];
  wire         new_w    = cmr[`CMOH_C_CTRL] ? ifflag[cur][`CMOH_F_NEW] : fresh_data_flag[obj];
  wire         ip_w     = cmr[`CMOH_C_CTRL] ? ifflag[cur][`CMOH_F_IP] : obj_irq_pending[obj];
  wire         txr_w    = cmr[`CMOH_C_TXND] | (cmr[`CMOH_C_CTRL] ? ifflag[cur][`CMOH_F_TXR] : send_request_flag[obj]);
  wire         if_write = (state == S_IF_DO) && cmr[`CMOH_C_WR];
  // Remote answer raising a request this cycle; must outlive a same-cycle done
  wire         rmt_set  = (state == S_SC_CMP) && rx_rtr && ram_q[`CMOH_W_DIR] && ram_q[`CMOH_W_REMOTE_ANSWER_ENABLE] &&
                          accept(ram_q, object_valid[obj]);
  reg  [135:0] rx_word;
  wire         ram_we   = if_write || (state == S_RX_WR);
  wire [135:0] ram_wd   = if_write ? merged : rx_word;

  // [RL12] Identifier, length and data land in the object
  always @* begin
    rx_word = ram_q;
    rx_word[`CMOH_W_ID]   = rx_id;
    rx_word[`CMOH_W_XTD]  = rx_xtd;
    rx_word[`CMOH_W_DLC]  = rx_dlc;
    // [RL13] Overrun when a data frame arrives while fresh data is still unread
    rx_word[`CMOH_W_LOST] = ram_q[`CMOH_W_LOST] | (fresh_data_flag[obj] & ~rx_rtr);
    if (!rx_rtr) begin
      rx_word[63:0] = rx_data;
    end
  end

  cmoh_ram u_ram (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (ram_we),
    .addr    (obj),
    .wdata   (ram_wd),
    .rdata   (ram_q)
  );

  // [RL18] Lowest object number wins
  cmoh_prio u_prio (
    .req   (object_valid & send_request_flag),
    .found (pick_found),
    .index (pick_idx)
  );

  // --------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------
  always @* begin
    next_rdata = 16'h0000;
    if (hit[1]) begin
      case (off)
        `CMOH_R_CRR: next_rdata = {ifbusy[hit[0]], 9'h000, ifnum[hit[0]]};
        `CMOH_R_CMR: next_rdata = {8'h00, ifcmr[hit[0]]};
        `CMOH_R_M1:  next_rdata = ifbuf[hit[0]][`CMOH_W_MSKL];
        // Reserved bit of the second mask register reads as one
        `CMOH_R_M2:  next_rdata = {ifbuf[hit[0]][`CMOH_W_MASK_EXTENDED_FLAG], ifbuf[hit[0]][`CMOH_W_MASK_TRANSMIT_SIDE], 1'b1,
                                   ifbuf[hit[0]][`CMOH_W_MSKH]};
        `CMOH_R_A1:  next_rdata = ifbuf[hit[0]][`CMOH_W_IDL];
        `CMOH_R_A2:  next_rdata = {ifflag[hit[0]][`CMOH_F_VAL], ifbuf[hit[0]][`CMOH_W_XTD],
                                   ifbuf[hit[0]][`CMOH_W_DIR], ifbuf[hit[0]][`CMOH_W_IDH]};
        `CMOH_R_MCR: next_rdata = {ifflag[hit[0]][`CMOH_F_NEW], ifbuf[hit[0]][`CMOH_W_LOST],
                                   ifflag[hit[0]][`CMOH_F_IP], ifbuf[hit[0]][`CMOH_W_USE_ACCEPTANCE_MASK],
                                   ifbuf[hit[0]][`CMOH_W_SEND_IRQ_ENABLE], ifbuf[hit[0]][`CMOH_W_RECEIVE_IRQ_ENABLE],
                                   ifbuf[hit[0]][`CMOH_W_REMOTE_ANSWER_ENABLE], ifflag[hit[0]][`CMOH_F_TXR],
                                   ifbuf[hit[0]][`CMOH_W_EOB], 3'b000, ifbuf[hit[0]][`CMOH_W_DLC]};
        `CMOH_R_DA1: next_rdata = ifbuf[hit[0]][15:0];
        `CMOH_R_DA2: next_rdata = ifbuf[hit[0]][31:16];
        `CMOH_R_DB1: next_rdata = ifbuf[hit[0]][47:32];
        `CMOH_R_DB2: next_rdata = ifbuf[hit[0]][63:48];
        default:     next_rdata = 16'h0000;
      endcase
    end else begin
      case (bus_addr)
        `CMOH_R_CTL:  next_rdata = {15'h0000, config_hold};
        `CMOH_R_TXR1: next_rdata = send_request_flag[15:0];
        `CMOH_R_TXR2: next_rdata = send_request_flag[31:16];
        `CMOH_R_ND1:  next_rdata = fresh_data_flag[15:0];
        `CMOH_R_ND2:  next_rdata = fresh_data_flag[31:16];
        `CMOH_R_IP1:  next_rdata = obj_irq_pending[15:0];
        `CMOH_R_IP2:  next_rdata = obj_irq_pending[31:16];
        `CMOH_R_MV1:  next_rdata = object_valid[15:0];
        `CMOH_R_MV2:  next_rdata = object_valid[31:16];
        default:      next_rdata = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Control: bus writes, handler state machine, transmit outcome
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state             <= S_IDLE;
      bus_rdata         <= 16'h0000;
      config_hold       <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        ifbuf[i]  <= 136'h0;
        ifflag[i] <= 4'h0;
        ifcmr[i]  <= 8'h00;
        ifnum[i]  <= 6'h00;
      end
      ifbusy            <= 2'b00;
      cur               <= 1'b0;
      obj               <= 5'h00;
      // [RL1] The four status flag vectors are cleared; RAM object words are kept
      object_valid      <= 32'h0;
      fresh_data_flag   <= 32'h0;
      send_request_flag <= 32'h0;
      obj_irq_pending   <= 32'h0;
      tx_busy           <= 1'b0;
      tx_obj            <= 5'h00;
      tx_ie             <= 1'b0;
      rx_pend           <= 1'b0;
      rx_id             <= 29'h0;
      rx_xtd            <= 1'b0;
      rx_rtr            <= 1'b0;
      rx_dlc            <= 4'h0;
      rx_data           <= 64'h0;
      core_tx_load      <= 1'b0;
      core_tx_id        <= 29'h0;
      core_tx_xtd       <= 1'b0;
      core_tx_rtr       <= 1'b0;
      core_tx_dlc       <= 4'h0;
      core_tx_data      <= 64'h0;
    end else begin
      bus_rdata    <= bus_rd ? next_rdata : 16'h0000;
      core_tx_load <= 1'b0;
      if (bus_wr && bus_addr == `CMOH_R_CTL) begin
        config_hold <= bus_wdata[0];
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (bus_wr && hit[1] && hit[0] == i) begin
          case (off)
            `CMOH_R_CRR: begin
              // [RL4] Busy rises on a request for objects 1..32
              if (!ifbusy[i] && bus_wdata[5:0] != 6'h00 && bus_wdata[5:0] <= `CMOH_OBJ_MAX) begin
                ifnum[i]  <= bus_wdata[5:0];
                ifbusy[i] <= 1'b1;
              end
            end
            `CMOH_R_CMR: ifcmr[i] <= bus_wdata[7:0];
            `CMOH_R_M1:  ifbuf[i][`CMOH_W_MSKL] <= bus_wdata;
            `CMOH_R_M2:  {ifbuf[i][`CMOH_W_MASK_EXTENDED_FLAG], ifbuf[i][`CMOH_W_MASK_TRANSMIT_SIDE], ifbuf[i][`CMOH_W_MSKH]}
                           <= {bus_wdata[15:14], bus_wdata[12:0]};
            `CMOH_R_A1:  ifbuf[i][`CMOH_W_IDL] <= bus_wdata;
            `CMOH_R_A2:  {ifflag[i][`CMOH_F_VAL], ifbuf[i][`CMOH_W_XTD], ifbuf[i][`CMOH_W_DIR],
                          ifbuf[i][`CMOH_W_IDH]} <= bus_wdata;
            `CMOH_R_MCR: begin
              {ifflag[i][`CMOH_F_NEW], ifbuf[i][`CMOH_W_LOST], ifflag[i][`CMOH_F_IP],
               ifbuf[i][`CMOH_W_USE_ACCEPTANCE_MASK], ifbuf[i][`CMOH_W_SEND_IRQ_ENABLE], ifbuf[i][`CMOH_W_RECEIVE_IRQ_ENABLE],
               ifbuf[i][`CMOH_W_REMOTE_ANSWER_ENABLE], ifflag[i][`CMOH_F_TXR], ifbuf[i][`CMOH_W_EOB]}
                <= bus_wdata[15:7];
              ifbuf[i][`CMOH_W_DLC] <= bus_wdata[3:0];
            end
            `CMOH_R_DA1: ifbuf[i][15:0]  <= bus_wdata;
            `CMOH_R_DA2: ifbuf[i][31:16] <= bus_wdata;
            `CMOH_R_DB1: ifbuf[i][47:32] <= bus_wdata;
            `CMOH_R_DB2: ifbuf[i][63:48] <= bus_wdata;
            default: ;
          endcase
        end
      end
      // Receive capture; a new frame during a scan would replace this one
      if (core_rx_valid) begin
        rx_pend <= 1'b1;
        rx_id   <= core_rx_id;
        rx_xtd  <= core_rx_xtd;
        rx_rtr  <= core_rx_rtr;
        rx_dlc  <= core_rx_dlc;
        rx_data <= core_rx_data;
      end
      case (state)
        S_IDLE: begin
          if (rx_pend && !config_hold) begin
            // [RL11] Scan begins at object 1
            obj   <= 5'h00;
            state <= S_SC_RD;
            if (!core_rx_valid) rx_pend <= 1'b0;
          end else if (ifbusy != 2'b00) begin
            cur   <= ~ifbusy[0];
            obj   <= ifbusy[0] ? ifnum[0][4:0] - 5'h01 : ifnum[1][4:0] - 5'h01;
            state <= S_IF_RD;
          // [RL7] Core ready and no interface transfer pending
          end else if (core_tx_ready && !tx_busy && pick_found && !config_hold) begin
            obj   <= pick_idx;
            state <= S_TX_RD;
          end
        end
        S_IF_RD: state <= S_IF_DO;
        S_IF_DO: begin
          if (cmr[`CMOH_C_WR]) begin
            // [RL3] Buffer merged into the object, flags as well
            object_valid[obj]      <= val_w;
            fresh_data_flag[obj]   <= new_w;
            obj_irq_pending[obj]   <= ip_w;
            send_request_flag[obj] <= txr_w;
            // [RL6] Buffer takes the whole stored object back
            ifbuf[cur]  <= merged;
            ifflag[cur] <= {val_w, new_w, ip_w, txr_w};
          end else begin
            // [RL6] Only selected parts refresh the buffer
            ifbuf[cur] <= (ram_q & sel_m) | (ifbuf[cur] & ~sel_m);
            if (cmr[`CMOH_C_ARB]) ifflag[cur][`CMOH_F_VAL] <= object_valid[obj];
            if (cmr[`CMOH_C_CTRL]) begin
              ifflag[cur][`CMOH_F_NEW] <= fresh_data_flag[obj];
              ifflag[cur][`CMOH_F_IP]  <= obj_irq_pending[obj];
              ifflag[cur][`CMOH_F_TXR] <= send_request_flag[obj];
            end
            if (cmr[`CMOH_C_CLRIP]) obj_irq_pending[obj] <= 1'b0;
            if (cmr[`CMOH_C_TXND])  fresh_data_flag[obj] <= 1'b0;
          end
          // [RL4] Transfer done, busy falls
          ifbusy[cur] <= 1'b0;
          state       <= S_IDLE;
        end
        S_TX_RD: state <= S_TX_LD;
        S_TX_LD: begin
          // [RL7] Load the shift register and start sending
          core_tx_load         <= 1'b1;
          core_tx_id           <= ram_q[`CMOH_W_ID];
          core_tx_xtd          <= ram_q[`CMOH_W_XTD];
          core_tx_rtr          <= ~ram_q[`CMOH_W_DIR];
          core_tx_dlc          <= ram_q[`CMOH_W_DLC];
          core_tx_data         <= ram_q[63:0];
          fresh_data_flag[obj] <= 1'b0;
          tx_busy              <= 1'b1;
          tx_obj               <= obj;
          tx_ie                <= ram_q[`CMOH_W_SEND_IRQ_ENABLE];
          state                <= S_IDLE;
        end
        S_SC_RD: state <= S_SC_CMP;
        S_SC_CMP: begin
          // [RL11] First match stops the scan
          if (accept(ram_q, object_valid[obj])) begin
            state <= S_IDLE;
            if (!rx_rtr) begin
              state <= S_RX_WR;
            end else if (ram_q[`CMOH_W_DIR] && ram_q[`CMOH_W_REMOTE_ANSWER_ENABLE]) begin
              // [RL16] Remote answer: only the request is raised
              send_request_flag[obj] <= 1'b1;
            end else if (ram_q[`CMOH_W_DIR] && ram_q[`CMOH_W_USE_ACCEPTANCE_MASK]) begin
              // [RL17] Masked remote frame is stored without data
              state <= S_RX_WR;
            end
          end else if (obj == `CMOH_OBJ_END) begin
            state <= S_IDLE;
          end else begin
            obj   <= obj + 5'h01;
            state <= S_SC_RD;
          end
        end
        S_RX_WR: begin
          // [RL13] Stored frame is marked fresh
          fresh_data_flag[obj]   <= 1'b1;
          // [RL15] A stored frame cancels the pending request
          send_request_flag[obj] <= 1'b0;
          // [RL14] Received data frame raises pending when enabled
          if (!rx_rtr && ram_q[`CMOH_W_RECEIVE_IRQ_ENABLE]) obj_irq_pending[obj] <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      // Outcome handled last; a same-cycle interface set on the object survives
      if (tx_busy && core_tx_done) begin
        tx_busy <= 1'b0;
        // [RL8] Keep the request if new data arrived meanwhile
        if (!fresh_data_flag[tx_obj] && !((if_write || rmt_set) && obj == tx_obj)) send_request_flag[tx_obj] <= 1'b0;
        // [RL9] Transmit success raises pending when enabled
        if (tx_ie) obj_irq_pending[tx_obj] <= 1'b1;
      end else if (tx_busy && core_tx_fail) begin
        // [RL10] Request stays set; selection reruns by priority
        tx_busy <= 1'b0;
      end
    end
  end
endmodule // cmoh_handler

// ### cmoh_handler_assertions.sv
/* Port checker of the message object handler.
   Assumes one clock and the bind below. */
`timescale 1ns/10ps
module cmoh_chk (
  input wire        clk,
  input wire        reset_n,
  input wire        bus_rd,
  input wire [15:0] bus_rdata,
  input wire        core_tx_ready,
  input wire        core_tx_done,
  input wire        core_tx_fail,
  input wire        core_tx_load,
  input wire [28:0] core_tx_id,
  input wire [63:0] core_tx_data,
  input wire        config_hold
);
  reg tx_out;
  // Frame handed to the core and not yet answered
  always @(posedge clk or negedge reset_n)
    if (!reset_n) tx_out <= 1'b0;
    else if (core_tx_load | core_tx_done | core_tx_fail) tx_out <= core_tx_load;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reselection needs decide, read and load
  sequence s_quiet; !core_tx_load [*3]; endsequence
  a_load_pulse: assert property (core_tx_load |=> !core_tx_load) else $error("long load");
  a_load_ready: assert property (core_tx_load |-> $past(core_tx_ready, 3)) else $error("load unready");
  a_one_frame: assert property (core_tx_load |-> !tx_out) else $error("load while busy");
  a_retry_gap: assert property ((core_tx_done || core_tx_fail) |=> s_quiet) else $error("early load");
  a_hold_stop: assert property (config_hold [*4] |-> !core_tx_load) else $error("load in hold");
  a_tx_held: assert property (!core_tx_load |-> $stable({core_tx_id, core_tx_data})) else $error("field moved");
  a_rdata_zero: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000) else $error("stray read");
  a_hold_reset: assert property ($rose(reset_n) |-> config_hold) else $error("hold clear");
endmodule // cmoh_chk
bind cmoh_handler cmoh_chk u_chk (.*);

// ### cmoh_core_model.sv
/* Protocol core stand-in: answers loads, sends frames.
   Assumes the handler clock. */
`timescale 1ns/10ps
module cmoh_core (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        core_tx_load,
  output reg         core_tx_ready,
  output reg         core_tx_done,
  output reg         core_tx_fail,
  output reg         core_rx_valid = 1'b0,
  output reg  [28:0] core_rx_id = 29'h0,
  output reg         core_rx_xtd = 1'b0,
  output reg         core_rx_rtr = 1'b0,
  output reg  [3:0]  core_rx_dlc = 4'h0,
  output reg  [63:0] core_rx_data = 64'h0
);
  reg       fail_next = 1'b0;
  reg [4:0] cnt;
  reg [1:0] slow;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) {core_tx_ready, core_tx_done, core_tx_fail, cnt, slow} <= 10'h200;
    else begin
      core_tx_done <= cnt == 5'h01 && !fail_next;
      core_tx_fail <= cnt == 5'h01 && fail_next;
      if (core_tx_load) begin
        core_tx_ready <= 1'b0;
        // Answer delay grows over four loads, then starts over
        cnt <= {slow, 3'h2};
        slow <= slow + 2'h1;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
        core_tx_ready <= cnt == 5'h01;
        fail_next <= fail_next && cnt != 5'h01;
      end
    end
  // Idle lines show the inverse, not the stale frame
  task send(input [28:0] id, input rtr, input [63:0] d);
    {core_rx_valid, core_rx_id, core_rx_xtd, core_rx_rtr} <= {1'b1, id, 1'b0, rtr};
    {core_rx_dlc, core_rx_data} <= {4'h8, d};
    @(posedge clk);
    {core_rx_valid, core_rx_id, core_rx_xtd, core_rx_rtr} <= {1'b0, ~id, 1'b1, ~rtr};
    {core_rx_dlc, core_rx_data} <= {4'h7, ~d};
  endtask
endmodule // cmoh_core

// ### tb.sv
/* Bench of the message object handler.
   Assumes cmoh_core as protocol core. */
`timescale 1ns/10ps
module tb;
  reg         clk = 1'b0, reset_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  reg  [8:0]  bus_addr = 9'h000;
  reg  [15:0] bus_wdata = 16'h0000, q;
  reg  [31:0] rs = 32'h00000041;
  reg  [63:0] d3, d5, d7;
  wire [15:0] bus_rdata;
  wire [28:0] core_tx_id, core_rx_id;
  wire [63:0] core_tx_data, core_rx_data;
  wire [31:0] obj_irq_pending;
  wire [3:0]  core_tx_dlc, core_rx_dlc;
  wire        core_tx_ready, core_tx_done, core_tx_fail, core_tx_load, core_tx_xtd, core_tx_rtr;
  wire        core_rx_valid, core_rx_xtd, core_rx_rtr, config_hold;
  integer     n_mismatch = 0, n_checks = 0, n, k, j;
  always #10 clk = ~clk;
  cmoh_handler dut (.*);
  cmoh_core core (.*);
  function [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function [15:0] arb2(input dir, input [10:0] s); return {2'b10, dir, s, 2'b00}; endfunction
  task chk(input [63:0] g, e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [8:0] a, input [15:0] d);
    {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
    @(posedge clk) bus_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input [8:0] a);
    {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge clk) bus_rd <= 1'b0;
    #1 q = bus_rdata;
    @(posedge clk);
  endtask
  task xfer(input [8:0] b, input [15:0] c, input [5:0] num);
    wr(b + 9'h004, c);
    wr(b, {10'h000, num});
    rd(b);
    chk(q[15], 1'b1);
    for (k = 0; k < 40 && q[15]; k = k + 1) rd(b);
    chk(q[15], 1'b0);
  endtask
  task obj(input [5:0] num, input [15:0] arb, ctl, input [63:0] d);
    for (j = 0; j < 3; j = j + 1) wr(9'h028 + 9'(4 * j), 16'h0000);
    wr(9'h034, arb);
    wr(9'h038, ctl);
    for (j = 0; j < 4; j = j + 1) wr(9'h03C + 9'(4 * j), d[16 * j +: 16]);
    xfer(9'h020, 16'h00F3, num);
  endtask
  task tx_exp(input [10:0] s, input [63:0] d);
    @(posedge clk) #1;
    for (k = 0; k < 300 && !core_tx_load; k = k + 1) @(posedge clk) #1;
    chk(core_tx_load, 1'b1);
    chk(core_tx_id, {s, 18'h00000});
    chk(core_tx_data, d);
    @(posedge clk);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Run needs some 1400 cycles; about twenty times that
  initial begin
    #600000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    {d3, d5, d7} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (n = 1; n <= 32; n = n + 1) obj(6'(n), 16'h0000, 16'h0000, d7);
    obj(6'h05, arb2(1'b1, 11'h000), 16'h0888, d5);
    obj(6'h03, arb2(1'b1, 11'h7FF), 16'h0A88, d3);
    xfer(9'h020, 16'h0084, 6'h03);
    xfer(9'h020, 16'h0084, 6'h05);
    core.fail_next = 1'b1;
    wr(9'h000, 16'h0000);
    tx_exp(11'h7FF, d3);
    tx_exp(11'h7FF, d3);
    tx_exp(11'h000, d5);
    repeat (40) @(posedge clk);
    chk(obj_irq_pending, 32'h00000014);
    rd(9'h100);
    chk(q, 16'h0000);
    obj(6'h07, arb2(1'b0, 11'h555), 16'h0488, d7);
    repeat (2) begin
      d7 = {rnd(), rnd()};
      core.send({11'h555, 18'h00000}, 1'b0, d7);
      repeat (100) @(posedge clk);
    end
    chk(obj_irq_pending, 32'h00000054);
    xfer(9'h080, 16'h007F, 6'h07);
    rd(9'h098);
    chk(q, 16'hE488);
    rd(9'h09C);
    chk(q, d7[15:0]);
    core.send({11'h000, 18'h00000}, 1'b1, d3);
    repeat (100) @(posedge clk);
    rd(9'h100);
    chk(q, 16'h0000);
    core.send({11'h7FF, 18'h00000}, 1'b1, d3);
    tx_exp(11'h7FF, d3);
    // Mid-run reset: flags clear, object contents survive
    reset_n <= 1'b0;
    @(posedge clk) reset_n <= 1'b1;
    @(posedge clk);
    xfer(9'h080, 16'h007F, 6'h07);
    rd(9'h09C);
    chk(q, d7[15:0]);
    rd(9'h160);
    chk(q, 16'h0000);
    end_of_test;
  end
endmodule // tb
